/* rtl/ident_cfg.svh */
// identification parameter block: offsets, reset values and fixed word contents
// assumes a 32-bit axi4-lite bus with an 8-bit byte address
`ifndef IDENT_CFG_SVH
`define IDENT_CFG_SVH
// register byte offsets
`define OFF_CTRL   8'h00
`define OFF_MULT   8'h04
`define OFF_XFER   8'h08
`define OFF_CYL    8'h0C
`define OFF_HEAD   8'h10
`define OFF_SPT    8'h14
`define OFF_TOTAL  8'h18
`define OFF_WIDX   8'h1C
`define OFF_WDATA  8'h20
`define OFF_STAT   8'h24
`define NUM_REGS   4'hA
`define RESP_OKAY  2'h0
`define RESP_SLVERR 2'h2
// reset values of host-visible settings
`define RST_CYL    16'h3FFF
`define RST_HEAD   4'hF
`define RST_SPT    8'h3F
`define RST_TOTAL  32'h00FBFC10
`define RST_MULT   8'h01
`define RST_MDMA   3'h0
`define RST_UDMA   7'h20
`define MULT_MAX   8'h01
// field positions
`define XFER_MDMA_LSB 0
`define XFER_UDMA_LSB 8
`define LAST_WORD  8'hFF
// fixed word contents
`define W_GENCFG   16'h045A
`define W_BUFTYPE  16'h0002
`define W_MULTMAX  16'h8001
`define W_CAPAB    16'h0F00
`define W_CAPAB2   16'h4000
`define W_PIOTIM   16'h0200
`define W_VALID    16'h0007
`define W_MULTVLD  8'h01
`define W_MDMASUP  8'h07
`define W_APIO     16'h0003
`define W_MDMA_MIN 16'h0078
`define W_MDMA_REC 16'h0078
`define W_PIO_NOFC 16'h0078
`define W_PIO_FC   16'h0078
`define W_SATACAP  16'h0006
`define W_SATAFEAT 16'h0008
`define W_ATAVER   16'h0080
`define W_FS82     16'h742B
`define W_FS83     16'h5500
`define W_FS84     16'h4002
`define W_FE85     16'h7429
`define W_FE86     16'h1400
`define W_FE87     16'h4002
`define W_UDMASUP  8'h7F
`define W_SECERASE 16'h0003
`define W_MPWREV   16'hFFFE
`define W_SECSTAT  16'h0001
`define W_ROTATE   16'h0001
`define W_SPACES   16'h2020
`define W_MODEL0   16'h5353
`define W_MODEL1   16'h4420
`define W_SERLAST  16'h3031
`define W_FWREV    16'h312E
`endif

/* rtl/ident_pkg.sv */
// identification parameter block: shared types
// assumes ident_cfg.svh for all numeric constants
package ident_pkg;
  // current geometry and capacity as the host sees it
  typedef struct packed {
    logic [15:0] cyl;
    logic [3:0]  head;
    logic [7:0]  spt;
    logic [31:0] total;
    logic [31:0] cap;
  } geom_t;
  // host-changeable transfer settings
  typedef struct packed {
    logic [7:0] mult;
    logic [2:0] mdma;
    logic [6:0] udma;
  } xfer_sel_t;
  typedef enum logic {ST_IDLE, ST_SEND} send_state_t;
endpackage

/* rtl/ident_block.sv */
// identification parameter block: 256-word table, axi4-lite slave, word stream out
// assumes one clock, synchronous reset, and a consumer of the stream on the same clock
//
// Implementation choices: the address map and register access over AXI4-Lite.
`include "ident_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ident_block
  import ident_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             id_valid,
  output logic [15:0]      id_data,
  output logic             id_last,
  input  wire logic        id_ready
);

  // one word of the table, from its index and the live settings
  function automatic logic [15:0] word_at(input logic [7:0] i, input geom_t g,
                                          input xfer_sel_t s);
    logic [15:0] w;
    w = 16'h0000; // reserved zero
    case (i)
      8'h00: w = `W_GENCFG;
      8'h01: w = g.cyl;
      8'h03: w = {12'h000, g.head};
      8'h06: w = {8'h00, g.spt};
      8'h07: w = g.total[31:16];
      8'h08: w = g.total[15:0];
      8'h13: w = `W_SERLAST;
      8'h14: w = `W_BUFTYPE;
      8'h15: w = `W_BUFTYPE;
      8'h17: w = `W_FWREV;
      8'h1B: w = `W_MODEL0;
      8'h1C: w = `W_MODEL1;
      8'h2F: w = `W_MULTMAX;
      8'h31: w = `W_CAPAB;
      8'h32: w = `W_CAPAB2;
      8'h33: w = `W_PIOTIM;
      8'h35: w = `W_VALID;
      8'h36: w = g.cyl;
      8'h37: w = {12'h000, g.head};
      8'h38: w = {8'h00, g.spt};
      8'h39: w = g.cap[15:0];
      8'h3A: w = g.cap[31:16];
      8'h3B: w = {7'h00, 1'b1, s.mult};
      8'h3C: w = g.total[15:0];
      8'h3D: w = g.total[31:16];
      8'h3F: w = {5'h00, s.mdma, `W_MDMASUP};
      8'h40: w = `W_APIO;
      8'h41: w = `W_MDMA_MIN;
      8'h42: w = `W_MDMA_REC;
      8'h43: w = `W_PIO_NOFC;
      8'h44: w = `W_PIO_FC;
      8'h4C: w = `W_SATACAP;
      8'h4E: w = `W_SATAFEAT;
      8'h50: w = `W_ATAVER;
      8'h52: w = `W_FS82;
      8'h53: w = `W_FS83;
      8'h54: w = `W_FS84;
      8'h55: w = `W_FE85;
      8'h56: w = `W_FE86;
      8'h57: w = `W_FE87;
      8'h58: w = {1'b0, s.udma, `W_UDMASUP};
      8'h59: w = `W_SECERASE;
      8'h5C: w = `W_MPWREV;
      8'h80: w = `W_SECSTAT;
      8'hD9: w = `W_ROTATE;
      default: begin
        if (((i >= 8'h0A) && (i <= 8'h12)) || ((i >= 8'h18) && (i <= 8'h1A))
            || ((i >= 8'h1D) && (i <= 8'h2E))) begin
          w = `W_SPACES;
        end
      end
    endcase
    return w;
  endfunction

  // settings and state
  geom_t       geom_q;
  xfer_sel_t   sel_q;
  send_state_t state_q;
  logic [7:0]  idx_q;
  logic [15:0] data_q;
  logic [7:0]  widx_q;
  // axi holding registers
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // register view by word index
  logic [31:0] view [0:9];
  assign view[0] = {31'h00000000, state_q == ST_SEND};
  assign view[1] = {24'h000000, sel_q.mult};
  assign view[2] = {17'h00000, sel_q.udma, 5'h00, sel_q.mdma};
  assign view[3] = {16'h0000, geom_q.cyl};
  assign view[4] = {28'h0000000, geom_q.head};
  assign view[5] = {24'h000000, geom_q.spt};
  assign view[6] = geom_q.total;
  assign view[7] = {24'h000000, widx_q};
  assign view[8] = {16'h0000, word_at(widx_q, geom_q, sel_q)};
  assign view[9] = {16'h0000, idx_q, 7'h00, state_q == ST_SEND};

  // write decode and byte-lane merge
  wire        wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire [3:0]  aw_idx  = awaddr_q[5:2];
  wire        aw_hit  = (awaddr_q[7:6] == 2'h0) && (aw_idx < `NUM_REGS);
  wire [31:0] wr_old  = aw_hit ? view[aw_idx] : 32'h00000000;
  wire [31:0] wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wr_val  = (wdata_q & wr_mask) | (wr_old & ~wr_mask);
  wire        wr_ok   = wr_fire && aw_hit;
  wire        wr_ctrl = wr_ok && (awaddr_q == `OFF_CTRL);
  wire        wr_mult = wr_ok && (awaddr_q == `OFF_MULT);
  wire        wr_xfer = wr_ok && (awaddr_q == `OFF_XFER);
  wire        wr_cyl  = wr_ok && (awaddr_q == `OFF_CYL);
  wire        wr_head = wr_ok && (awaddr_q == `OFF_HEAD);
  wire        wr_spt  = wr_ok && (awaddr_q == `OFF_SPT);
  wire        wr_tot  = wr_ok && (awaddr_q == `OFF_TOTAL);
  wire        wr_widx = wr_ok && (awaddr_q == `OFF_WIDX);

  wire        mult_ok = wr_val[7:0] <= `MULT_MAX;
  // one selected dma mode at most across mdma and udma
  wire [9:0]  dma_sel = {wr_val[`XFER_UDMA_LSB +: 7], wr_val[`XFER_MDMA_LSB +: 3]};
  wire        sel_ok  = (dma_sel & (dma_sel - 10'h001)) == 10'h000;

  // read decode
  wire        rd_take = arvalid && !rvalid_q;
  wire [3:0]  ar_idx  = araddr[5:2];
  wire        ar_hit  = (araddr[7:6] == 2'h0) && (ar_idx < `NUM_REGS);

  // axi handshake outputs
  assign awready = !aw_held_q;
  assign wready  = !w_held_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // write channel: address and data taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= aw_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= ar_hit ? view[ar_idx] : 32'h00000000;
      rresp_q  <= ar_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // host settings; rejected values leave the old setting
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q.mult   <= `RST_MULT;
      sel_q.mdma   <= `RST_MDMA;
      sel_q.udma   <= `RST_UDMA;
      geom_q.cyl   <= `RST_CYL;
      geom_q.head  <= `RST_HEAD;
      geom_q.spt   <= `RST_SPT;
      geom_q.total <= `RST_TOTAL;
      geom_q.cap   <= 32'h00000000;
      widx_q       <= 8'h00;
    end else begin
      // capacity product, one cycle behind the geometry
      geom_q.cap <= {16'h0000, geom_q.cyl} * {28'h0000000, geom_q.head}
                    * {24'h000000, geom_q.spt};
      if (wr_mult && mult_ok) sel_q.mult <= wr_val[7:0];
      if (wr_xfer && sel_ok) begin
        sel_q.mdma <= wr_val[`XFER_MDMA_LSB +: 3];
        sel_q.udma <= wr_val[`XFER_UDMA_LSB +: 7];
      end
      if (wr_cyl)  geom_q.cyl   <= wr_val[15:0];
      if (wr_head) geom_q.head  <= wr_val[3:0];
      if (wr_spt)  geom_q.spt   <= wr_val[7:0];
      if (wr_tot)  geom_q.total <= wr_val;
      if (wr_widx) widx_q       <= wr_val[7:0];
    end
  end

  // stream outputs
  wire id_step = (state_q == ST_SEND) && id_ready;
  assign id_valid = state_q == ST_SEND;
  assign id_last  = (state_q == ST_SEND) && (idx_q == `LAST_WORD);
  assign id_data  = data_q;

  // ascending word stream, 256 words per start
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      idx_q   <= 8'h00;
      data_q  <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_ctrl && wr_val[0]) begin
            state_q <= ST_SEND;
            idx_q   <= 8'h00;
            data_q  <= word_at(8'h00, geom_q, sel_q);
          end
        end
        ST_SEND: begin
          if (id_step) begin
            if (idx_q == `LAST_WORD) begin
              state_q <= ST_IDLE;
            end else begin
              idx_q  <= idx_q + 8'h01;
              data_q <= word_at(idx_q + 8'h01, geom_q, sel_q);
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // checks on the words as they leave and on the capacity product
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_gencfg;
    id_valid && idx_q == 8'h00 |-> id_data == 16'h045A && id_data[6];
  endproperty
  a_gencfg: assert property (p_gencfg) else $error("general config word wrong");

  property p_mult;
    id_valid && idx_q == 8'h3B |-> id_data[15:8] == 8'h01 && id_data[7:0] <= 8'h01;
  endproperty
  a_mult: assert property (p_mult) else $error("multiple setting word wrong");

  property p_valid;
    id_valid && idx_q == 8'h35 |-> id_data[2:0] == 3'h7;
  endproperty
  a_valid: assert property (p_valid) else $error("validity bits not set");

  property p_mdma;
    id_valid && idx_q == 8'h3F |-> $onehot0(id_data[15:8]) && id_data[15:11] == 5'h00
      && id_data[7:0] == 8'h07;
  endproperty
  a_mdma: assert property (p_mdma) else $error("mdma word malformed");

  property p_apio;
    id_valid && idx_q == 8'h40 |-> id_data == 16'h0003;
  endproperty
  a_apio: assert property (p_apio) else $error("advanced pio word wrong");

  property p_cyc;
    id_valid && idx_q == 8'h42 |-> id_data >= 16'h0078;
  endproperty
  a_cyc: assert property (p_cyc) else $error("recommended cycle below minimum");

  property p_udma;
    id_valid && idx_q == 8'h58 |-> id_data[7:0] == 8'h7F && !id_data[15]
      && $onehot0(id_data[14:8]);
  endproperty
  a_udma: assert property (p_udma) else $error("udma word malformed");

  property p_cap;
    !rst |=> geom_q.cap == {16'h0000, $past(geom_q.cyl)} * {28'h0000000, $past(geom_q.head)}
      * {24'h000000, $past(geom_q.spt)};
  endproperty
  a_cap: assert property (p_cap) else $error("capacity not the geometry product");

  property p_order;
    id_valid && id_ready && !id_last |=> id_valid && idx_q == $past(idx_q) + 8'h01;
  endproperty
  a_order: assert property (p_order) else $error("words out of order");

  property p_end;
    id_valid && id_ready && id_last |=> !id_valid;
  endproperty
  a_end: assert property (p_end) else $error("stream did not end after last word");

  property p_hold;
    id_valid && !id_ready |=> id_valid && $stable(id_data) && $stable(idx_q);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");

  property p_rot;
    id_valid && idx_q == 8'hD9 |-> id_data == 16'h0001;
  endproperty
  a_rot: assert property (p_rot) else $error("rotation rate word wrong");

  // main scenarios
  c_full: cover property (id_valid && id_ready && id_last);
  c_stall: cover property (id_valid && !id_ready ##1 id_valid && id_ready);
  c_write: cover property (wr_xfer && sel_ok);
  c_reject: cover property (wr_mult && !mult_ok);

endmodule // ident_block

`default_nettype wire

/* bench/ident_host_model.sv */
// host side of the identification stream: takes words and keeps them by arrival order
// assumes the block's clock and reset; stall makes ready drop three cycles out of four
`timescale 1ns/1ps
`default_nettype none
module ident_host_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        stall,
  input  wire logic        id_valid,
  input  wire logic [15:0] id_data,
  input  wire logic        id_last,
  output logic             id_ready
);
  logic [15:0] mem [256];
  logic [8:0]  cnt;
  logic [7:0]  last_idx;
  logic [8:0]  n_last;
  logic [1:0]  ph_q;
  // ready pattern, changed only after an edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q     <= 2'h0;
      id_ready <= 1'b0;
    end else begin
      ph_q     <= ph_q + 2'h1;
      id_ready <= !stall || (ph_q == 2'h3);
    end
  end
  // capture every accepted word, note where the last flag came
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      cnt    <= 9'h0;
      n_last <= 9'h0;
    end else if (id_valid && id_ready) begin
      mem[cnt[7:0]] <= id_data;
      cnt           <= cnt + 9'h1;
      if (id_last) begin
        n_last   <= n_last + 9'h1;
        last_idx <= cnt[7:0];
      end
    end
  end
endmodule // ident_host_model
`default_nettype wire

/* bench/test_identify_parameter_block.sv */
// self-checking bench: axi4-lite master tasks, host stream model, word expectations
// assumes ident_cfg.svh offsets and a 40 MHz clock
`include "ident_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_identify_parameter_block;
  import ident_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, clr, stall;
  logic awready, wready, bvalid, arready, rvalid, id_valid, id_last, id_ready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd;
  logic [3:0]  wstrb, strb;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] cyl_m, id_data;
  logic [3:0]  head_m;
  logic [7:0]  spt_m, mult_m;
  logic [31:0] tot_m;
  logic [2:0]  mdma_m;
  logic [6:0]  udma_m;
  int errors, n_checks;
  ident_block dut_u (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .id_valid(id_valid), .id_data(id_data), .id_last(id_last), .id_ready(id_ready));
  ident_host_model host_u (.clk(clk), .rst(rst), .clr(clr), .stall(stall),
    .id_valid(id_valid), .id_data(id_data), .id_last(id_last), .id_ready(id_ready));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // expected word; bit 16 set means the word is checked
  function automatic logic [16:0] exp_word(input int i);
    logic [31:0] cap;
    cap = cyl_m * head_m * spt_m;
    case (i)
      0: return {1'b1, 16'h045A};
      7: return {1'b1, tot_m[31:16]};
      8: return {1'b1, tot_m[15:0]};
      19: return {1'b1, 16'h3031};
      27: return {1'b1, 16'h5353};
      46: return {1'b1, 16'h2020};
      47: return {1'b1, 16'h8001};
      49: return {1'b1, 16'h0F00};
      51: return {1'b1, 16'h0200};
      53: return {1'b1, 16'h0007};
      54: return {1'b1, cyl_m};
      55: return {1'b1, 12'h0, head_m};
      56: return {1'b1, 8'h0, spt_m};
      57: return {1'b1, cap[15:0]};
      58: return {1'b1, cap[31:16]};
      59: return {1'b1, 8'h01, mult_m};
      60: return {1'b1, tot_m[15:0]};
      61: return {1'b1, tot_m[31:16]};
      63: return {1'b1, 5'h0, mdma_m, 8'h07};
      64: return {1'b1, 16'h0003};
      65, 66, 67, 68: return {1'b1, 16'h0078};
      76: return {1'b1, 16'h0006};
      88: return {1'b1, 1'b0, udma_m, 8'h7F};
      89: return {1'b1, 16'h0003};
      217: return {1'b1, 16'h0001};
      default: return {((i >= 69 && i <= 75) || (i >= 93 && i <= 127) ||
                        (i >= 161 && i <= 216) || i >= 218), 16'h0};
    endcase
  endfunction
  task automatic chk_word(input int i, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR word %0d expected %h seen %h", i, e, g);
    end
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    logic ta, tw, tb;
    t = 0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= strb; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb) r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      t++;
    end while (!tb && t < 100);
    if (!tb) chk_reg("bvalid", 32'h1, 32'h0);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    logic ta, tr;
    t = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      #1;
      ta = arvalid && arready;
      tr = rvalid && rready;
      if (tr) begin d = rdata; r = rresp; end
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      t++;
    end while (!tr && t < 100);
    if (!tr) chk_reg("rvalid", 32'h1, 32'h0);
  endtask
  // start a stream, wait for all words, compare every known word
  task automatic run_stream(input logic st);
    logic [16:0] e;
    int t;
    stall <= st;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    axi_write(`OFF_CTRL, 32'h1, rs);
    chk_reg("start resp", {30'h0, `RESP_OKAY}, {30'h0, rs});
    axi_read(`OFF_STAT, rd, rs);
    chk_reg("busy flag", 32'h1, rd & 32'h1);
    chk_reg("stat resp", {30'h0, `RESP_OKAY}, {30'h0, rs});
    // a second start while busy must not restart the stream
    axi_write(`OFF_CTRL, 32'h1, rs);
    t = 0;
    while (host_u.cnt !== 9'd256 && t < 3000) begin @(posedge clk); t++; end
    repeat (8) @(posedge clk);
    chk_reg("word count", 32'd256, {23'h0, host_u.cnt});
    chk_reg("last flag count", 32'd1, {23'h0, host_u.n_last});
    chk_reg("last index", 32'd255, {24'h0, host_u.last_idx});
    for (int i = 0; i < 256; i++) begin
      e = exp_word(i);
      if (e[16]) chk_word(i, e[15:0], host_u.mem[i]);
    end
    axi_read(`OFF_CTRL, rd, rs);
    chk_reg("idle flag", 32'h0, rd);
    $display("test stream stall=%0d done", st);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(25ns * 40000);
    errors++;
    summarize();
  end
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0;
    clr = 1'b0; stall = 1'b0; errors = 0; n_checks = 0; seed = 32'h9CDE;
    strb = 4'hF;
    cyl_m = 16'h3FFF; head_m = 4'hF; spt_m = 8'h3F; tot_m = 32'h00FBFC10;
    mult_m = 8'h01; mdma_m = 3'h0; udma_m = 7'h20;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values of the settings
    axi_read(`OFF_MULT, rd, rs);
    chk_reg("mult", 32'h01, rd);
    axi_read(`OFF_XFER, rd, rs);
    chk_reg("xfer", 32'h2000, rd);
    axi_read(`OFF_TOTAL, rd, rs);
    chk_reg("total", 32'h00FBFC10, rd);
    axi_read(8'h28, rd, rs);
    chk_reg("unmapped read resp", 32'h2, {30'h0, rs});
    axi_write(8'h28, 32'hFFFF, rs);
    chk_reg("unmapped write resp", 32'h2, {30'h0, rs});
    axi_write(`OFF_WIDX, 32'h0, rs);
    axi_read(`OFF_WDATA, rd, rs);
    chk_reg("word window", 32'h045A, rd);
    $display("test registers done");
    run_stream(1'b0);
    // random geometry, refused settings, mdma mode 2 selected
    seed = lfsr(seed);
    cyl_m = seed[15:0] | 16'h1;
    head_m = seed[19:16] | 4'h1;
    spt_m = seed[27:20] | 8'h1;
    seed = lfsr(seed);
    tot_m = seed;
    axi_write(`OFF_CYL, {16'h0, cyl_m}, rs);
    axi_write(`OFF_HEAD, {28'h0, head_m}, rs);
    axi_write(`OFF_SPT, {24'h0, spt_m}, rs);
    axi_write(`OFF_TOTAL, tot_m, rs);
    axi_write(`OFF_MULT, 32'h0, rs);
    mult_m = 8'h00;
    axi_write(`OFF_MULT, 32'h2, rs);
    axi_write(`OFF_XFER, 32'h4, rs);
    mdma_m = 3'h4;
    udma_m = 7'h0;
    axi_write(`OFF_XFER, 32'h3, rs);
    // byte lanes: udma select merged with the held mdma select is refused
    strb = 4'h2;
    axi_write(`OFF_XFER, 32'h4000, rs);
    strb = 4'h1;
    axi_write(`OFF_CYL, 32'hFFFF005A, rs);
    strb = 4'hF;
    cyl_m = {cyl_m[15:8], 8'h5A};
    axi_read(`OFF_XFER, rd, rs);
    chk_reg("xfer merged", {17'h0, udma_m, 5'h0, mdma_m}, rd);
    axi_read(`OFF_CYL, rd, rs);
    chk_reg("cyl low lane", {16'h0, cyl_m}, rd);
    axi_read(`OFF_MULT, rd, rs);
    chk_reg("mult kept", 32'h0, rd);
    run_stream(1'b1);
    summarize();
  end
endmodule // test_identify_parameter_block
`default_nettype wire
